// ==== rtl/fps_pkg.sv ====
/*
 * Constants, timing counts and state encoding of the flyback protection
 * sequencer. Assumes a single 10 MHz core clock.
 */
package fps_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SW_PERIOD_NS   = 10000;
  localparam int LP_PERIOD_NS   = 40000;
  localparam int LEB_NS         = 300;
  localparam int PRECHARGE_NS   = 20000;
  localparam int MAX_DUTY_PCT   = 80;
  localparam int SW_PER_CYC     = SW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LP_PER_CYC     = LP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MAX_ON_CYC     = (SW_PER_CYC * MAX_DUTY_PCT) / 100;
  localparam int LEB_CYC        = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_CYC        = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Counter widths and typed limits
  // ****************************************
  localparam int CNT_W = 9;
  localparam int EVT_W = 4;
  localparam int PRE_W = 8;
  localparam logic [CNT_W-1:0] SW_LAST     = CNT_W'(SW_PER_CYC - 1);
  localparam logic [CNT_W-1:0] LP_LAST     = CNT_W'(LP_PER_CYC - 1);
  localparam logic [CNT_W-1:0] MAX_ON_LAST = CNT_W'(MAX_ON_CYC - 1);
  localparam logic [CNT_W-1:0] LEB_LIM     = CNT_W'(LEB_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST    = PRE_W'(PRE_CYC - 1);
  localparam logic [EVT_W-1:0] OVP_TRIP    = 4'h8;
  localparam logic [EVT_W-1:0] MD_TRIP     = 4'h8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_QUALIFY = 7'h02,
    ST_PRECHG  = 7'h04,
    ST_RUN     = 7'h08,
    ST_TCHARGE = 7'h10,
    ST_PDOWN   = 7'h20,
    ST_LATCH   = 7'h40
  } seq_state_t;

endpackage

// ==== rtl/fps_sync.sv ====
/*
 * Two-flop synchroniser for a vector of comparator levels.
 * Assumes each bit is a slow level from outside the clock domain.
 */
`timescale 1ns/1ps
module fps_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // fps_sync

// ==== rtl/flyback_protection_sequencer.sv ====
/*
 * Start-up, switching and protection sequencer of a flyback controller.
 * Assumes comparator levels from the analog front end on its inputs and
 * one 10 MHz core clock; gate drive and timer controls are registered.
 */
// Contract
// - After supply start, wait for line-sense start and protect-low before continuing.
// - Precharge current sense to soft-start level, then begin switching.
// - Any protection stops switching at once; restart or latch by type.
// - Protection restart fast-charges timer pin, then power-down until low level.
// - Leave power-down only with timer below low level and supply above start.
// - Latched protection enters power-down at once, held until supply removal.
// - Restart variant: undervoltage stops switching, restart mode, gate held off.
// - Latch variant: undervoltage outside start-up latches the device off.
// - Count consecutive overvoltage cycles; eight trigger the latched protection.
// - Overvoltage gone before eight clears the overvoltage counter.
// - Line-sense low detect during operation stops switching and restarts.
// - Protect input above high or below low level latches off.
// - Every stroke ends by the maximum duty limit.
// - Eight consecutive max-duty strokes activate the restart protection.
// - Source overload timer current while control level exceeds threshold.
// - Timer pin at overload level triggers overload protection.
// - Overload restarts in restart variant, latches in latch variant.
// - Ignore current sense during blanking after each turn-on.
// - End stroke when sensed current reaches the control level.
// - At low power clamp peak limit to quarter and lower frequency.
// - Overtemperature shutdown is latched, cleared only by supply loss.
`timescale 1ns/1ps
module flyback_protection_sequencer
  import fps_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Variant select
  input  wire logic variant_latch,
  // Supply comparators
  input  wire logic supply_start_ok,
  input  wire logic supply_undervolt_lockout,
  input  wire logic supply_overvolt_prot,
  input  wire logic supply_removed,
  // Line and protect comparators
  input  wire logic line_sense_in,
  input  wire logic line_sense_low,
  input  wire logic protect_low_ok,
  input  wire logic protect_high,
  input  wire logic overtemp,
  // Timer pin comparators
  input  wire logic fault_timer_upper,
  input  wire logic fault_timer_lower,
  input  wire logic fault_timer_pin,
  // Control comparators
  input  wire logic ctrl_above_overload,
  input  wire logic current_sense_in,
  input  wire logic low_power_det,
  // Outputs
  output logic      gate_drive,
  output logic      gate_enable,
  output logic      ss_precharge,
  output logic      timer_fast_charge,
  output logic      overload_source,
  output logic      low_power_limit,
  output logic      power_down,
  output logic      latched_off
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [14:0] raw_in;
  logic [14:0] sync_q;
  logic        var_l_s, start_s, supply_undervolt_lockout_s, ovp_s, removed_s;
  logic        line_ok_s, line_low_s, plow_ok_s, phigh_s, otp_s;
  logic        t_up_s, t_low_s, overload_protection, ctrl_over_s, cs_s, lp_s;

  assign raw_in = {variant_latch, supply_start_ok, supply_undervolt_lockout,
                   supply_overvolt_prot, supply_removed, line_sense_in,
                   line_sense_low, protect_low_ok, protect_high, overtemp,
                   fault_timer_upper, fault_timer_lower, fault_timer_pin,
                   ctrl_above_overload, current_sense_in};

  fps_sync #(.W(15)) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d        (raw_in),
    .q        (sync_q)
  );

  assign {var_l_s, start_s, supply_undervolt_lockout_s, ovp_s, removed_s, line_ok_s, line_low_s,
          plow_ok_s, phigh_s, otp_s, t_up_s, t_low_s, overload_protection,
          ctrl_over_s, cs_s} = sync_q;

  logic lp_meta_r;
  logic lp_sync_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lp_meta_r <= 1'b0;
      lp_sync_r <= 1'b0;
    end else begin
      lp_meta_r <= low_power_det;
      lp_sync_r <= lp_meta_r;
    end
  end
  assign lp_s = lp_sync_r;

  // ****************************************
  // State and counters
  // ****************************************
  seq_state_t       st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [EVT_W-1:0] ovp_cnt_r, ovp_cnt_nxt;
  logic [EVT_W-1:0] md_cnt_r, md_cnt_nxt;
  logic             gate_drive_nxt;
  logic             gate_enable_nxt, ss_precharge_nxt, timer_fast_charge_nxt;
  logic             overload_source_nxt, low_power_limit_nxt, power_down_nxt, latched_off_nxt;
  logic [CNT_W-1:0] per_last;
  logic             per_end, cs_end, md_end, stroke_end;
  logic             ovp_trip, md_trip, latch_evt, restart_evt, supply_undervolt_lockout_evt, prot_stop;

  assign per_last   = lp_s ? LP_LAST : SW_LAST;
  assign per_end    = (cnt_r >= per_last);
  assign cs_end     = gate_drive && (cnt_r >= LEB_LIM) && cs_s;
  assign md_end     = gate_drive && (cnt_r == MAX_ON_LAST);
  assign stroke_end = cs_end || md_end;
  assign ovp_trip   = per_end && ovp_s && (ovp_cnt_r == OVP_TRIP - 4'h1);
  assign md_trip    = md_end && !cs_end && (md_cnt_r == MD_TRIP - 4'h1);
  assign latch_evt  = phigh_s || !plow_ok_s || otp_s || ovp_trip
                   || (var_l_s && (supply_undervolt_lockout_s || overload_protection));
  assign restart_evt = line_low_s || md_trip
                    || (!var_l_s && overload_protection);
  assign supply_undervolt_lockout_evt   = !var_l_s && supply_undervolt_lockout_s;
  assign prot_stop  = (st_r == ST_RUN) && (latch_evt || restart_evt || supply_undervolt_lockout_evt);

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = per_last;
    pre_nxt     = PRE_RST;
    ovp_cnt_nxt = EVT_RST;
    md_cnt_nxt  = EVT_RST;
    case (st_r)
      ST_IDLE: begin
        if (start_s) begin
          st_nxt = ST_QUALIFY;
        end
      end
      ST_QUALIFY: begin
        if (otp_s) begin
          st_nxt = ST_LATCH;
        end else if (supply_undervolt_lockout_s) begin
          st_nxt = ST_IDLE;
        end else if (line_ok_s && plow_ok_s) begin
          st_nxt = ST_PRECHG;
        end
      end
      ST_PRECHG: begin
        pre_nxt = pre_r + 8'h01;
        if (otp_s || phigh_s) begin
          st_nxt = ST_LATCH;
        end else if (supply_undervolt_lockout_s) begin
          st_nxt = ST_IDLE;
        end else if (pre_r == PRE_LAST) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_nxt     = per_end ? CNT_RST : cnt_r + 9'h001;
        ovp_cnt_nxt = ovp_cnt_r;
        md_cnt_nxt  = md_cnt_r;
        if (per_end) begin
          ovp_cnt_nxt = ovp_s ? ovp_cnt_r + 4'h1 : EVT_RST;
        end
        if (stroke_end) begin
          md_cnt_nxt = cs_end ? EVT_RST : md_cnt_r + 4'h1;
        end
        if (latch_evt) begin
          st_nxt = ST_LATCH;
        end else if (restart_evt) begin
          st_nxt = ST_TCHARGE;
        end else if (supply_undervolt_lockout_evt) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_TCHARGE: begin
        if (otp_s) begin
          st_nxt = ST_LATCH;
        end else if (t_up_s) begin
          st_nxt = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (otp_s) begin
          st_nxt = ST_LATCH;
        end else if (t_low_s && start_s) begin
          st_nxt = ST_QUALIFY;
        end
      end
      ST_LATCH: begin
        if (removed_s) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Gate drive
  // ****************************************
  always_comb begin
    gate_drive_nxt = 1'b0;
    if ((st_r == ST_RUN) && !prot_stop) begin
      if (per_end) begin
        gate_drive_nxt = 1'b1;
      end else begin
        gate_drive_nxt = gate_drive && !stroke_end;
      end
    end
  end

  always_comb begin
    gate_enable_nxt       = (st_nxt == ST_RUN);
    ss_precharge_nxt      = (st_nxt == ST_PRECHG);
    timer_fast_charge_nxt = (st_nxt == ST_TCHARGE);
    overload_source_nxt   = (st_nxt == ST_RUN) && ctrl_over_s;
    low_power_limit_nxt   = (st_nxt == ST_RUN) && lp_s;
    power_down_nxt        = (st_nxt == ST_TCHARGE) || (st_nxt == ST_PDOWN) || (st_nxt == ST_LATCH);
    latched_off_nxt       = (st_nxt == ST_LATCH);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r              <= ST_IDLE;
      cnt_r             <= CNT_RST;
      pre_r             <= PRE_RST;
      ovp_cnt_r         <= EVT_RST;
      md_cnt_r          <= EVT_RST;
      gate_drive        <= 1'b0;
      gate_enable       <= 1'b0;
      ss_precharge      <= 1'b0;
      timer_fast_charge <= 1'b0;
      overload_source   <= 1'b0;
      low_power_limit   <= 1'b0;
      power_down        <= 1'b0;
      latched_off       <= 1'b0;
    end else begin
      st_r              <= st_nxt;
      cnt_r             <= cnt_nxt;
      pre_r             <= pre_nxt;
      ovp_cnt_r         <= ovp_cnt_nxt;
      md_cnt_r          <= md_cnt_nxt;
      gate_drive        <= gate_drive_nxt;
      gate_enable       <= gate_enable_nxt;
      ss_precharge      <= ss_precharge_nxt;
      timer_fast_charge <= timer_fast_charge_nxt;
      overload_source   <= overload_source_nxt;
      low_power_limit   <= low_power_limit_nxt;
      power_down        <= power_down_nxt;
      latched_off       <= latched_off_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_qualify_first: assert property (
    (st_r == ST_QUALIFY && !(line_ok_s && plow_ok_s)) |=> st_r != ST_PRECHG)
    else $error("Precharge began before start conditions");

  a_gate_after_pre: assert property (
    $rose(gate_enable) |-> $past(ss_precharge))
    else $error("Switching began without precharge");

  a_prot_stops: assert property (
    prot_stop |=> !gate_drive && !gate_enable)
    else $error("Protection did not stop switching");

  a_restart_charge: assert property (
    (st_r == ST_RUN && restart_evt && !latch_evt) |=> timer_fast_charge ##0 power_down)
    else $error("Restart did not fast-charge timer");

  a_pdown_hold: assert property (
    (st_r == ST_PDOWN && !otp_s && !(t_low_s && start_s)) |=> st_r == ST_PDOWN)
    else $error("Power-down left early");

  a_latch_hold: assert property (
    (st_r == ST_LATCH && !removed_s) |=> latched_off && !gate_drive)
    else $error("Latch released without supply removal");

  a_supply_undervolt_lockout_latch: assert property (
    (st_r == ST_RUN && var_l_s && supply_undervolt_lockout_s) |=> st_r == ST_LATCH)
    else $error("Latch variant undervoltage did not latch");

  a_ovp_trip: assert property (
    (st_r == ST_RUN && ovp_trip) |=> latched_off)
    else $error("Eighth overvoltage cycle did not latch");

  a_ovp_clear: assert property (
    (st_r == ST_RUN && per_end && !ovp_s && !prot_stop) |=> ovp_cnt_r == EVT_RST)
    else $error("Overvoltage counter not cleared");

  a_max_duty: assert property (
    gate_drive |-> cnt_r <= MAX_ON_LAST)
    else $error("Stroke exceeded maximum duty");

  a_blanking: assert property (
    (gate_drive && cnt_r < LEB_LIM && !prot_stop) |=> gate_drive)
    else $error("Stroke ended inside blanking");

  a_overload_src: assert property (
    (st_r == ST_RUN && ctrl_over_s && !prot_stop) |=> overload_source)
    else $error("Overload timer current not sourced");

  c_run: cover property (st_r == ST_PRECHG ##1 st_r == ST_RUN);
  c_latch: cover property (st_r == ST_RUN ##1 st_r == ST_LATCH);
  c_restart: cover property (st_r == ST_PDOWN ##1 st_r == ST_QUALIFY);
  c_md_end: cover property (md_end && !cs_end);

endmodule // flyback_protection_sequencer

// ==== tb/fps_sense_model.sv ====
/*
 * Model of the power switch and the current-sense network.
 * Assumes the sensed current climbs while the gate is high and falls to
 * zero at once when the gate goes low.
 */
`timescale 1ns/1ps
module fps_sense_model (
  // Clock
  input  wire logic       core_clk,
  // Switch side
  input  wire logic       gate_drive,
  input  wire logic [7:0] ramp_cyc,
  output logic            current_sense_in
);
  logic [7:0] on_cnt;

  // ****************************************
  // Current ramp
  // ****************************************
  always_ff @(posedge core_clk) begin
    on_cnt <= gate_drive ? on_cnt + 8'h01 : 8'h00;
  end

  // Control level reached after ramp_cyc on-cycles; 8'hff never reaches it
  assign current_sense_in = gate_drive && (ramp_cyc != 8'hff) && (on_cnt >= ramp_cyc);
endmodule // fps_sense_model

// ==== tb/flyback_protection_sequencer_tb_top.sv ====
/*
 * Self-checking bench of the flyback protection sequencer.
 * Assumes a 10 MHz core clock; inputs change at falling edges.
 */
`timescale 1ns/1ps
module flyback_protection_sequencer_tb_top;
  import fps_pkg::*;

  logic       core_clk, rst_b, variant_latch, supply_start_ok, supply_undervolt_lockout;
  logic       supply_overvolt_prot, supply_removed, line_sense_in, line_sense_low;
  logic       protect_low_ok, protect_high, overtemp, fault_timer_upper, fault_timer_lower;
  logic       fault_timer_pin, ctrl_above_overload, current_sense_in, low_power_det;
  logic       gate_drive, gate_enable, ss_precharge, timer_fast_charge, overload_source;
  logic       low_power_limit, power_down, latched_off;
  logic [7:0] ramp_cyc;
  logic [4:0] outs;
  int         mismatches;
  int         comparisons;

  assign outs = {gate_drive, latched_off, power_down, gate_enable, ss_precharge};

  // ****************************************
  // Instances
  // ****************************************
  flyback_protection_sequencer i_flyback_protection_sequencer (.*);
  fps_sense_model i_fps_sense_model (
    .core_clk         (core_clk),
    .gate_drive       (gate_drive),
    .ramp_cyc         (ramp_cyc),
    .current_sense_in (current_sense_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_out(input int idx, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (outs[idx] === v) return;
    end
    check(16'(outs), 16'hdead);
    summarize();
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic reset_dut(input logic v);
    rst_b = 1'b0;
    variant_latch = v;
    idle(5);
    rst_b = 1'b1;
  endtask

  task automatic restore();
    if (latched_off === 1'b1) begin
      supply_removed = 1'b1;
      wait_out(3, 1'b0);
      supply_removed = 1'b0;
    end else if (power_down === 1'b1) begin
      fault_timer_upper = 1'b1;
      idle(10);
      fault_timer_lower = 1'b1;
    end
    wait_out(1, 1'b1);
    fault_timer_upper = 1'b0;
    fault_timer_lower = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_startup();
    supply_start_ok = 1'b1;
    idle(30);
    check(16'(outs), 16'h0);
    line_sense_in = 1'b1;
    wait_out(0, 1'b1);
    check(16'(gate_drive), 16'h0);
    wait_out(1, 1'b1);
    check(16'(ss_precharge), 16'h0);
    $display("startup done");
  endtask

  task automatic t_max_duty();
    int len;
    ramp_cyc = 8'hff;
    len = 0;
    wait_out(4, 1'b1);
    while (gate_drive === 1'b1 && len < 200) begin
      len++;
      @(negedge core_clk);
    end
    check(16'(len), 16'(MAX_ON_CYC));
    wait_out(2, 1'b1);
    check(16'({timer_fast_charge, latched_off, gate_drive}), 16'h4);
    ramp_cyc = 8'h14;
    $display("max duty done");
  endtask

  task automatic t_restart();
    fault_timer_upper = 1'b1;
    idle(10);
    check(16'({timer_fast_charge, power_down}), 16'h1);
    supply_start_ok = 1'b0;
    fault_timer_lower = 1'b1;
    idle(30);
    check(16'(outs), 16'h4);
    supply_start_ok = 1'b1;
    restore();
    $display("restart done");
  endtask

  task automatic t_line_low();
    line_sense_low = 1'b1;
    wait_out(2, 1'b1);
    check(16'({timer_fast_charge, latched_off}), 16'h2);
    line_sense_low = 1'b0;
    restore();
    $display("line low done");
  endtask

  task automatic t_latch(input int cause);
    protect_high = (cause == 0);
    protect_low_ok = (cause != 1);
    overtemp = (cause == 2);
    wait_out(3, 1'b1);
    check(16'({gate_enable, gate_drive, power_down}), 16'h1);
    protect_high = 1'b0;
    protect_low_ok = 1'b1;
    overtemp = 1'b0;
    idle(300);
    check(16'(latched_off), 16'h1);
    restore();
    $display("latch cause %0d done", cause);
  endtask

  task automatic t_ovp();
    supply_overvolt_prot = 1'b1;
    idle(450);
    supply_overvolt_prot = 1'b0;
    idle(250);
    supply_overvolt_prot = 1'b1;
    idle(650);
    check(16'(latched_off), 16'h0);
    wait_out(3, 1'b1);
    supply_overvolt_prot = 1'b0;
    restore();
    $display("overvoltage done");
  endtask

  task automatic t_variant(input logic v);
    reset_dut(v);
    restore();
    ctrl_above_overload = 1'b1;
    low_power_det = 1'b1;
    ramp_cyc = 8'h00;
    idle(8);
    check(16'({overload_source, low_power_limit}), 16'h3);
    ctrl_above_overload = 1'b0;
    low_power_det = 1'b0;
    ramp_cyc = 8'h14;
    fault_timer_pin = 1'b1;
    wait_out(2, 1'b1);
    check(16'(latched_off), 16'(v));
    fault_timer_pin = 1'b0;
    restore();
    supply_undervolt_lockout = 1'b1;
    wait_out(1, 1'b0);
    idle(5);
    check(16'({latched_off, gate_drive}), 16'({v, 1'b0}));
    supply_undervolt_lockout = 1'b0;
    restore();
    $display("variant %0d done", v);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    comparisons = 0;
    {variant_latch, supply_start_ok, supply_undervolt_lockout, supply_overvolt_prot} = 4'h0;
    {supply_removed, line_sense_in, line_sense_low, protect_high, overtemp} = 5'h00;
    {fault_timer_upper, fault_timer_lower, fault_timer_pin} = 3'h0;
    {ctrl_above_overload, low_power_det} = 2'h0;
    protect_low_ok = 1'b1;
    ramp_cyc = 8'h14;
    reset_dut(1'b0);
    t_startup();
    t_max_duty();
    t_restart();
    t_line_low();
    for (int c = 0; c < 3; c++) begin
      t_latch(c);
    end
    t_ovp();
    t_variant(1'b0);
    t_variant(1'b1);
    summarize();
  end
endmodule // flyback_protection_sequencer_tb_top
